// >>> rtl/uart_cfg_map.vh
// Constants for the host serial port line configuration block.
`ifndef UART_CFG_MAP_VH
`define UART_CFG_MAP_VH
`define CLK_HZ 32'h0773_5940
`define RATE_DEFAULT_CODE 24'h00_0003
`define RATE_MAX_CODE 24'h00_000A
`define RATE_CUSTOM_MIN 24'h00_04B0
`define RATE_CUSTOM_MAX 24'h0E_C400
`define RATE_LEGACY_MIN 24'h00_0960
`define RATE_LEGACY_MAX 24'h03_8400
`define PARITY_NONE 2'h0
`define PARITY_EVEN 2'h1
`define PARITY_ODD 2'h2
`define STOP_ONE 1'h0
`define STOP_TWO 1'h1
`define DATA_BITS 4'h8
`endif

// >>> rtl/host_uart_line_config.v
// Line configuration and serial framer for the host-facing asynchronous port.
`timescale 1ns/1ns
`include "uart_cfg_map.vh"
module host_uart_line_config
(
	input wire clk,
	input wire rst_b,
	input wire rate_write,
	input wire [23:0] rate_write_value,
	input wire saved_valid,
	input wire [23:0] saved_rate,
	input wire legacy_mode,
	input wire command_mode,
	input wire apply_changes_command,
	input wire [1:0] parity_setting,
	input wire stop_bit_setting,
	output reg [23:0] line_rate_setting,
	output reg [23:0] active_rate,
	output wire range_error,
	input wire tx_valid,
	input wire [7:0] tx_data,
	output wire tx_ready,
	output reg tx_line,
	input wire rx_pin,
	output reg [7:0] rx_data,
	output reg rx_valid,
	output reg rx_parity_error,
	output reg rx_frame_error
);
	localparam IDLE = 2'h0;
	localparam SEND = 2'h1;
	localparam RECV = 2'h1;
	reg [23:0] pending_divisor;
	reg [23:0] divisor;
	reg cmd_d;
	reg [23:0] next_store;
	reg sync1;
	reg sync2;
	reg [1:0] tx_state;
	reg [23:0] tx_cnt;
	reg [3:0] tx_idx;
	reg [11:0] tx_shift;
	reg [1:0] rx_state;
	reg [23:0] rx_cnt;
	reg [3:0] rx_idx;
	reg [11:0] rx_shift;
	reg [3:0] tx_len;
	reg [3:0] rx_len;
	reg par_on;
	reg par_bit;
	// Standard code table.
	function [23:0] code_rate;
		input [3:0] code;
		begin
			case (code)
				4'h0: code_rate = 24'h00_04B0;
				4'h1: code_rate = 24'h00_0960;
				4'h2: code_rate = 24'h00_12C0;
				4'h3: code_rate = 24'h00_2580;
				4'h4: code_rate = 24'h00_4B00;
				4'h5: code_rate = 24'h00_9600;
				4'h6: code_rate = 24'h00_E100;
				4'h7: code_rate = 24'h01_C200;
				4'h8: code_rate = 24'h03_8400;
				4'h9: code_rate = 24'h07_0800;
				default: code_rate = 24'h0E_1000;
			endcase
		end
	endfunction
	// Turns a setting into bits per second; legacy parts are clamped.
	function [23:0] eff_rate;
		input [23:0] v;
		input legacy;
		reg [23:0] r;
		begin
			r = (v <= `RATE_MAX_CODE) ? code_rate(v[3:0]) : v;
			if (legacy && r < `RATE_LEGACY_MIN)
				r = `RATE_LEGACY_MIN;
			if (legacy && r > `RATE_LEGACY_MAX)
				r = `RATE_LEGACY_MAX;
			eff_rate = r;
		end
	endfunction
	// Clock cycles per bit, rounded to the nearest whole cycle.
	function [23:0] div_of;
		input [23:0] rate;
		reg [31:0] q;
		begin
			q = (`CLK_HZ + {9'h000, rate[23:1]}) / {8'h00, rate};
			div_of = q[23:0];
		end
	endfunction
	// Achieved rate from a divisor, so readback shows what the line really runs at.
	function [23:0] rate_of;
		input [23:0] d;
		reg [31:0] q;
		begin
			q = (`CLK_HZ + {9'h000, d[23:1]}) / {8'h00, d};
			rate_of = q[23:0];
		end
	endfunction
	wire is_custom = rate_write_value >= `RATE_CUSTOM_MIN && rate_write_value <= `RATE_CUSTOM_MAX;
	wire write_ok = rate_write_value <= `RATE_MAX_CODE || is_custom;
	assign range_error = parity_setting > `PARITY_ODD;
	always @*
	begin
		next_store = rate_write_value;
		if (is_custom || legacy_mode)
			next_store = rate_of(div_of(eff_rate(rate_write_value, legacy_mode)));
		if (rate_write_value <= `RATE_MAX_CODE && !legacy_mode)
			next_store = rate_write_value;
	end
	wire apply = apply_changes_command || (cmd_d && !command_mode);
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			line_rate_setting <= saved_valid ? saved_rate : `RATE_DEFAULT_CODE;
			pending_divisor <= div_of(eff_rate(saved_valid ? saved_rate : `RATE_DEFAULT_CODE, legacy_mode));
			divisor <= div_of(eff_rate(saved_valid ? saved_rate : `RATE_DEFAULT_CODE, legacy_mode));
			active_rate <= rate_of(div_of(eff_rate(saved_valid ? saved_rate : `RATE_DEFAULT_CODE, legacy_mode)));
			cmd_d <= 1'b0;
		end
		else
		begin
			cmd_d <= command_mode;
			if (rate_write && write_ok)
			begin
				line_rate_setting <= next_store;
				pending_divisor <= div_of(eff_rate(rate_write_value, legacy_mode));
			end
			if (apply && tx_state == IDLE && rx_state == IDLE)
			begin
				divisor <= pending_divisor;
				active_rate <= rate_of(pending_divisor);
			end
		end
	end
	always @*
	begin
		par_on = parity_setting == `PARITY_EVEN || parity_setting == `PARITY_ODD;
		par_bit = (^tx_data) ^ (parity_setting == `PARITY_ODD);
		tx_len = `DATA_BITS + 4'h2 + {3'h0, par_on} + {3'h0, stop_bit_setting == `STOP_TWO};
		rx_len = `DATA_BITS + 4'h1 + {3'h0, par_on};
	end
	assign tx_ready = tx_state == IDLE;
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			tx_state <= IDLE;
			tx_cnt <= 24'h00_0000;
			tx_idx <= 4'h0;
			tx_shift <= 12'hFFF;
			tx_line <= 1'b1;
		end
		else
		begin
			case (tx_state)
				IDLE:
				begin
					tx_line <= 1'b1;
					if (tx_valid)
					begin
						tx_shift <= {2'b11, par_on ? par_bit : 1'b1, tx_data, 1'b0};
						tx_state <= SEND;
						tx_idx <= 4'h0;
						tx_cnt <= 24'h00_0000;
					end
				end
				SEND:
				begin
					tx_line <= par_on || tx_idx < 4'h9 ? tx_shift[tx_idx] : 1'b1;
					if (tx_cnt + 24'h00_0001 >= divisor)
					begin
						tx_cnt <= 24'h00_0000;
						if (tx_idx + 4'h1 >= tx_len)
							tx_state <= IDLE;
						tx_idx <= tx_idx + 4'h1;
					end
					else
						tx_cnt <= tx_cnt + 24'h00_0001;
				end
				default: tx_state <= IDLE;
			endcase
		end
	end
	// The receiver samples mid-bit; the pin is synchronised first.
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			rx_state <= IDLE;
			rx_cnt <= 24'h00_0000;
			rx_idx <= 4'h0;
			rx_shift <= 12'h000;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
			rx_parity_error <= 1'b0;
			rx_frame_error <= 1'b0;
		end
		else
		begin
			sync1 <= rx_pin;
			sync2 <= sync1;
			rx_valid <= 1'b0;
			case (rx_state)
				IDLE:
				if (!sync2)
				begin
					rx_state <= RECV;
					rx_cnt <= {1'b0, divisor[23:1]};
					rx_idx <= 4'h0;
				end
				RECV:
				if (rx_cnt + 24'h00_0001 >= divisor)
				begin
					rx_cnt <= 24'h00_0000;
					rx_shift[rx_idx] <= sync2;
					rx_idx <= rx_idx + 4'h1;
					if (rx_idx == rx_len)
					begin
						rx_state <= IDLE;
						rx_data <= rx_shift[8:1];
						rx_valid <= 1'b1;
						rx_frame_error <= !sync2;
						rx_parity_error <= par_on && ((^rx_shift[9:1]) != (parity_setting == `PARITY_ODD));
					end
				end
				else
					rx_cnt <= rx_cnt + 24'h00_0001;
				default: rx_state <= IDLE;
			endcase
		end
	end
endmodule

// >>> bench/uart_line_checker.sv
// Port checker for the line configuration block.
`timescale 1ns/1ns
module uart_line_checker(input wire clk, rst_b, rate_write, legacy_mode, command_mode, apply_changes_command,
	input wire saved_valid, input wire [23:0] saved_rate, rate_write_value, line_rate_setting, active_rate,
	input wire [1:0] parity_setting,
	input wire range_error, tx_valid, tx_ready, tx_line, rx_valid);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_rst; $rose(rst_b) |-> line_rate_setting == (saved_valid ? saved_rate : 24'h00_0003); endproperty
	a_rst: assert property (p_rst) else $error("reset rate");
	property p_err; range_error == (parity_setting == 2'h3); endproperty
	a_err: assert property (p_err) else $error("range flag");
	property p_idle; tx_ready |-> tx_line; endproperty
	a_idle: assert property (p_idle) else $error("idle level");
	property p_go; tx_valid && tx_ready |=> !tx_ready ##[0:1] !tx_line; endproperty
	a_go: assert property (p_go) else $error("start bit");
	property p_hold; !$stable(active_rate) |->
		$past(apply_changes_command | command_mode) || $past(apply_changes_command | command_mode, 2); endproperty
	a_hold: assert property (p_hold) else $error("early rate");
	property p_wr; rate_write && !legacy_mode && rate_write_value <= 24'h00_000A |=>
		line_rate_setting == $past(rate_write_value); endproperty
	a_wr: assert property (p_wr) else $error("code store");
	property p_bad; rate_write && (rate_write_value > 24'h0E_C400 ||
		rate_write_value inside {[24'h00_000B:24'h00_04AF]}) |=> $stable(line_rate_setting); endproperty
	a_bad: assert property (p_bad) else $error("bad value kept");
	property p_rx; rx_valid |=> !rx_valid; endproperty
	a_rx: assert property (p_rx) else $error("rx pulse");
endmodule
bind host_uart_line_config uart_line_checker chk_u(.*);

// >>> bench/host_link.sv
// Host end of the serial link.
`timescale 1ns/1ns
module host_link(input wire clk, input wire tx_line, output logic rx_pin);
	// Bit time for 921600 b/s; the device's rounding differs by well under a percent.
	int div = 136;
	logic [11:0] cap;
	initial rx_pin = 1'b1;
	task grab;
		@(negedge tx_line);
		repeat (div / 2) @(posedge clk);
		for (int i = 0; i < 12; i++)
		begin
			if (i > 0) repeat (div) @(posedge clk);
			#1;
			cap[i] = tx_line;
		end
	endtask
	task send(input logic [11:0] f);
		for (int i = 0; i < 12; i++)
		begin
			rx_pin = f[i];
			repeat (div) @(posedge clk);
			#1;
		end
	endtask
endmodule

// >>> bench/tb.sv
// Bench for the host serial line configuration block.
`timescale 1ns/1ns
module tb;
	logic clk = 0, rst_b = 0, wr = 0, lg = 0, cm = 0, ap = 0, sb = 1, tv = 0, rxp, txl, rdy, pe, re, rv, fe, sv = 0;
	logic [1:0] par = 2'h1;
	logic [7:0] td = 8'h00, rd;
	logic [23:0] wv = 24'h00_0000, lrs, ar, srt = 24'h00_0000;
	int n_errors = 0, num_checks = 0, cyc = 0, n_rx = 0;
	int rate[11] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400, 460800, 921600};
	always #4 clk = ~clk;
	host_uart_line_config dut_u(.clk(clk), .rst_b(rst_b), .rate_write(wr), .rate_write_value(wv), .saved_valid(sv),
		.saved_rate(srt), .legacy_mode(lg), .command_mode(cm), .apply_changes_command(ap), .parity_setting(par),
		.stop_bit_setting(sb), .line_rate_setting(lrs), .active_rate(ar), .range_error(re), .tx_valid(tv), .tx_data(td),
		.tx_ready(rdy), .tx_line(txl), .rx_pin(rxp), .rx_data(rd), .rx_valid(rv), .rx_parity_error(pe), .rx_frame_error(fe));
	host_link host_u(.clk(clk), .tx_line(txl), .rx_pin(rxp));
	// The valid strobe stands one cycle only, so pulses are counted as they pass.
	always @(posedge clk)
	begin
		if (rv === 1'b1)
			n_rx++;
	end
	task chk(input string n, input logic [23:0] e, input logic [23:0] s);
		num_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// Achieved rates are checked to one percent, since the divisor is rounded.
	function logic nr(input logic [23:0] v, input int r);
		return v * 100 > r * 99 && v * 100 < r * 101;
	endfunction
	task step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wrt(input logic [23:0] v);
		wv = v;
		wr = 1;
		step();
		wr = 0;
		step();
	endtask
	task apply;
		ap = 1;
		step();
		ap = 0;
		step(3);
	endtask
	task txf(input logic [7:0] d, input logic [11:0] f, input logic r);
		td = d;
		fork
			host_u.grab();
			begin
				tv = 1;
				step();
				tv = 0;
			end
		join
		chk("tx frame", f, host_u.cap);
		chk("tx busy", r, rdy);
		// Settings must not move under a frame in flight, so the next call starts from idle.
		while (rdy !== 1'b1)
			step();
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			results();
		end
	end
	initial
	begin
		step(4);
		rst_b = 1;
		chk("reset code", 24'h00_0003, lrs);
		chk("reset rate", 1, nr(ar, 9600));
		for (int i = 0; i < 11; i++)
		begin
			wrt(i);
			chk("code", i, lrs);
			apply();
			chk("rate", 1, nr(ar, rate[i]));
		end
		$display("codes done");
		wrt(24'h00_000B);
		chk("gap", 24'h00_000A, lrs);
		wrt(24'h0E_C401);
		chk("over", 24'h00_000A, lrs);
		cm = 1;
		wrt(24'h0E_C400);
		chk("custom", 1, nr(lrs, 967680));
		step(3);
		chk("held", 1, nr(ar, 921600));
		cm = 0;
		step(3);
		chk("exit", 1, nr(ar, 967680));
		lg = 1;
		wrt(24'h00_000A);
		chk("legacy max", 1, nr(lrs, 230400));
		wrt(24'h00_0000);
		chk("legacy min", 1, nr(lrs, 2400));
		lg = 0;
		wrt(24'h00_000A);
		apply();
		par = 2'h3;
		step();
		chk("range", 1, re);
		$display("settings done");
		par = 2'h1;
		txf(8'hA5, 12'hD4A, 1'b0);
		par = 2'h0;
		sb = 0;
		txf(8'h81, 12'hF02, 1'b1);
		par = 2'h2;
		sb = 1;
		host_u.send(12'hE78);
		chk("rx data", 8'h3C, rd);
		chk("rx parity", 0, pe);
		chk("rx stop", 0, fe);
		chk("rx count", 1, n_rx);
		host_u.send(12'hC78);
		chk("rx bad parity", 1, pe);
		chk("rx count", 2, n_rx);
		// A low stop bit flags the frame; the line still low then opens a stray frame that the reset below clears.
		host_u.send(12'hA78);
		chk("rx bad stop", 1, fe);
		chk("rx count", 3, n_rx);
		$display("frames done");
		sv = 1;
		srt = 24'h00_0007;
		rst_b = 0;
		step(4);
		rst_b = 1;
		chk("saved code", 24'h00_0007, lrs);
		chk("saved rate", 1, nr(ar, 115200));
		chk("idle line", 1, txl);
		chk("idle ready", 1, rdy);
		step(2);
		$display("reset done");
		results();
	end
endmodule
